// ---- rtl/sbcr_top.v ----
// Purpose: Command receiver control of a supply-modulated sensor bus slave
// Assumes: 20 MHz oscillator, power-on reset on reset_n_in
// Notes: Comparator, sense and data pins synchronised by two flops
`timescale 1ns/10ps
`default_nettype none
`include "sbcr_map.vh"
module sbcr_top (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_n_in,
  // Bus comparator and decoded bit stream
  input wire cmd_detect_in,
  input wire cmd_bit_in,
  input wire cmd_bit_strobe_in,
  // Mode and configuration
  input wire [1:0] op_mode_in,
  input wire chain_switch_close_in,
  // Response transmitter requests
  input wire resp_single_req_in,
  input wire resp_double_req_in,
  // Downstream current sense
  input wire downstream_sense_in,
  // Receiver status
  output reg cmd_start_out,
  output reg cmd_valid_out,
  output reg cmd_block_out,
  output reg high_ref_sampling_enable_out,
  // Link layer hand-over
  output reg [31:0] cmd_data_out,
  output reg [5:0] cmd_len_out,
  output reg cmd_ready_out,
  // Response current selects
  output reg response_current_level_out,
  output reg response_current_double_out,
  // Discovery result and chain switch
  output reg downstream_slave_out,
  output reg chain_switch_drive_out
);
  // ==========================================================
  // Declarations
  wire detect_s; // Synchronised comparator
  wire sense_s; // Synchronised current sense
  wire bit_s; // Synchronised bit value
  wire strobe_s; // Synchronised bit strobe
  reg strobe_d; // Strobe delay for edge
  reg [15:0] det_cnt; // Detection counter
  reg [15:0] next_det_cnt; // Next counter value
  reg [15:0] low_cnt; // Consecutive comparator low samples, microcut filter
  wire por_hit; // Sampling delay ends this cycle
  reg [15:0] por_cnt; // Power-on sampling delay
  reg por_done; // Power-on delay over
  reg [31:0] shift; // Command shift register
  reg [5:0] bit_cnt; // Bits received
  wire bit_take; // One bit arrives
  wire window_miss; // Validation not reached in time
  wire lockout_end; // Mode lockout expired
  wire start_clear; // Any start clear

  // ==========================================================
  // Per-mode decode, lockout length and command bit count
  function [15:0] lock_cycles;
    input [1:0] mode;
    begin
      case (mode)
        `SBCR_MODE_DISC: lock_cycles = `SBCR_LOCK_DISC_CYC;
        `SBCR_MODE_CRM: lock_cycles = `SBCR_LOCK_CRM_CYC;
        default: lock_cycles = `SBCR_LOCK_PDCM_CYC;
      endcase
    end
  endfunction

  function [5:0] cmd_bits;
    input [1:0] mode;
    begin
      case (mode)
        `SBCR_MODE_DISC: cmd_bits = `SBCR_BITS_DISC;
        `SBCR_MODE_CRM: cmd_bits = `SBCR_BITS_CRM;
        default: cmd_bits = `SBCR_BITS_PDCM;
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  sbcr_sync #(.RST_VAL(1'b1)) u_sync_det (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(cmd_detect_in),
    .sync_out(detect_s)
  );
  sbcr_sync #(.RST_VAL(1'b0)) u_sync_sense (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(downstream_sense_in),
    .sync_out(sense_s)
  );
  sbcr_sync #(.RST_VAL(1'b0)) u_sync_bit (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(cmd_bit_in),
    .sync_out(bit_s)
  );
  sbcr_sync #(.RST_VAL(1'b0)) u_sync_stb (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(cmd_bit_strobe_in),
    .sync_out(strobe_s)
  );

  // ==========================================================
  // Clear conditions of the start flag
  // Miss: window over while still below validation
  assign window_miss = cmd_start_out && !cmd_valid_out &&
    (det_cnt >= `SBCR_ONE_BIT_CYC);
  // Lockout counted from start, per mode
  assign lockout_end = cmd_start_out && (det_cnt >= lock_cycles(op_mode_in));
  assign start_clear = window_miss || lockout_end;
  // Power-on delay reaches its end on this edge
  assign por_hit = !por_done && (por_cnt >= `SBCR_SAMPLE_DELAY_CYC - 16'h0001);
  assign bit_take = strobe_s && !strobe_d && cmd_start_out && !cmd_block_out;

  // ==========================================================
  // Next counter value
  always @* begin
    next_det_cnt = det_cnt;
    if (start_clear) begin
      next_det_cnt = `SBCR_CNT_RST;
    end else if (cmd_start_out) begin
      next_det_cnt = det_cnt + 16'h0001;
    end else if (!detect_s) begin
      next_det_cnt = 16'h0001;
    end else begin
      next_det_cnt = `SBCR_CNT_RST;
    end
  end

  // ==========================================================
  // Counter, flags and sampling gate
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      det_cnt <= `SBCR_CNT_RST;
      cmd_start_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      high_ref_sampling_enable_out <= 1'b0;
      por_cnt <= `SBCR_CNT_RST;
      por_done <= 1'b0;
      low_cnt <= `SBCR_CNT_RST;
    end else begin
      det_cnt <= next_det_cnt;
      // Comparator low time, a high sample restarts it
      if (start_clear || detect_s) begin
        low_cnt <= `SBCR_CNT_RST;
      end else if (!cmd_start_out) begin
        low_cnt <= 16'h0001;
      end else if (!cmd_valid_out) begin
        low_cnt <= low_cnt + 16'h0001;
      end
      // Power-on delay before first sampling
      if (!por_done) begin
        if (por_hit) begin
          por_done <= 1'b1;
          // Not while a command runs, its clear enables later
          high_ref_sampling_enable_out <= !cmd_start_out;
        end else begin
          por_cnt <= por_cnt + 16'h0001;
        end
      end
      if (start_clear) begin
        cmd_start_out <= 1'b0;
        cmd_valid_out <= 1'b0;
        high_ref_sampling_enable_out <= por_done || por_hit;
      end else if (next_det_cnt == 16'h0001 && !cmd_start_out) begin
        cmd_start_out <= 1'b1;
        high_ref_sampling_enable_out <= 1'b0;
      end else if (cmd_start_out && !cmd_valid_out && !detect_s &&
                   low_cnt + 16'h0001 >= `SBCR_VALID_CYC) begin
        // Low long enough inside the window, microcuts never get here
        cmd_valid_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command assembly, block flag and hand-over
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_d <= 1'b0;
      shift <= 32'h00000000;
      bit_cnt <= 6'h00;
      cmd_block_out <= 1'b0;
      cmd_data_out <= 32'h00000000;
      cmd_len_out <= 6'h00;
      cmd_ready_out <= 1'b0;
    end else begin
      strobe_d <= strobe_s;
      cmd_ready_out <= 1'b0;
      if (start_clear) begin
        cmd_block_out <= 1'b0;
        bit_cnt <= 6'h00;
        shift <= 32'h00000000;
      end else if (bit_take && cmd_valid_out) begin
        shift <= {shift[30:0], bit_s};
        bit_cnt <= bit_cnt + 6'h01;
        if (bit_cnt + 6'h01 == cmd_bits(op_mode_in)) begin
          cmd_block_out <= 1'b1;
          cmd_data_out <= {shift[30:0], bit_s};
          cmd_len_out <= cmd_bits(op_mode_in);
          cmd_ready_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Response selects, discovery sense, chain switch
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      response_current_level_out <= 1'b0;
      response_current_double_out <= 1'b0;
      downstream_slave_out <= 1'b0;
      chain_switch_drive_out <= 1'b0;
    end else begin
      response_current_level_out <= resp_single_req_in;
      response_current_double_out <= resp_double_req_in;
      if (op_mode_in == `SBCR_MODE_DISC) begin
        downstream_slave_out <= sense_s;
      end
      chain_switch_drive_out <= chain_switch_close_in;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sbcr_map.vh ----
// Purpose: Constants of the sensor bus command receiver
// Assumes: 20 MHz reference clock, 50 ns period
// Notes: Times in ns, cycle counts derived from them
`ifndef SBCR_MAP_VH
`define SBCR_MAP_VH
// ==========================================================
// Clock
`define SBCR_CLK_PERIOD_NS 50
// ==========================================================
// Timing in ns
`define SBCR_ONE_BIT_WINDOW_NS 8000
`define SBCR_VALID_TIME_NS 1000
`define SBCR_LOCKOUT_DISC_NS 100000
`define SBCR_LOCKOUT_CRM_NS 200000
`define SBCR_LOCKOUT_PDCM_NS 50000
`define SBCR_SAMPLE_DELAY_NS 100000
// ==========================================================
// Cycle counts at the 50 ns clock, sized for the 16-bit counters
`define SBCR_ONE_BIT_CYC 16'h00A0
`define SBCR_VALID_CYC 16'h0014
`define SBCR_LOCK_DISC_CYC 16'h07D0
`define SBCR_LOCK_CRM_CYC 16'h0FA0
`define SBCR_LOCK_PDCM_CYC 16'h03E8
`define SBCR_SAMPLE_DELAY_CYC 16'h07D0
// ==========================================================
// Operating modes
`define SBCR_MODE_DISC 2'h0
`define SBCR_MODE_CRM 2'h1
`define SBCR_MODE_PDCM 2'h2
// ==========================================================
// Command lengths in bits per mode
`define SBCR_BITS_DISC 6'h01
`define SBCR_BITS_CRM 6'h20
`define SBCR_BITS_PDCM 6'h08
// ==========================================================
// Reset values
`define SBCR_CNT_RST 16'h0000
`endif

// ---- rtl/sbcr_sync.v ----
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Single destination clock
// Notes: First stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module sbcr_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_n_in,
  // Level in and out
  input wire async_in,
  output reg sync_out
);
  reg stage1; // First stage, metastable

  // ==========================================================
  // Synchroniser chain
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- test/sbcr_properties.sv ----
// Purpose: Port assertions of the command receiver
// Assumes: One clock, async active-low reset
// Notes: Attached by bind to sbcr_top
`timescale 1ns/10ps
`default_nettype none
module sbcr_properties (
  // Clock, reset and watched inputs
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic cmd_detect_in,
  input wire logic chain_switch_close_in,
  input wire logic resp_single_req_in,
  input wire logic resp_double_req_in,
  // Watched outputs
  input wire logic cmd_start_out,
  input wire logic cmd_valid_out,
  input wire logic cmd_block_out,
  input wire logic high_ref_sampling_enable_out,
  input wire logic cmd_ready_out,
  input wire logic response_current_level_out,
  input wire logic response_current_double_out,
  input wire logic chain_switch_drive_out
);
  // Cycles spent with a command in progress
  logic [12:0] run_len;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) run_len <= 13'h0000;
    else run_len <= cmd_start_out ? run_len + 13'h0001 : 13'h0000;
  end
  // Consecutive low samples of the comparator pin, saturating
  logic [5:0] low_len;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) low_len <= 6'h00;
    else if (cmd_detect_in) low_len <= 6'h00;
    else if (low_len != 6'h3F) low_len <= low_len + 6'h01;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_start_on_low: assert property (
    (!cmd_start_out && !cmd_detect_in)[*3] |=> cmd_start_out) else $error("start late");
  a_valid_at_count: assert property (
    $rose(cmd_valid_out) |-> $past(cmd_start_out, 19)) else $error("valid off count");
  a_valid_needs_low: assert property (
    $rose(cmd_valid_out) |-> $past(low_len, 2) >= 6'h14) else $error("valid without low time");
  a_window_miss_clear: assert property (
    cmd_start_out && !cmd_valid_out |-> run_len < 13'h00AA) else $error("window not closed");
  a_lockout_clear: assert property (
    cmd_start_out |-> run_len < 13'h0FB4) else $error("lockout not ended");
  a_flags_follow_start: assert property (
    !cmd_start_out |-> !cmd_valid_out && !cmd_block_out) else $error("flag kept");
  a_sample_stop: assert property (
    cmd_start_out |-> !high_ref_sampling_enable_out) else $error("sampling in command");
  a_sample_resume: assert property (
    $fell(cmd_start_out) && $past(reset_n_in) |-> high_ref_sampling_enable_out)
    else $error("sampling not resumed");
  a_ready_block: assert property (
    cmd_ready_out |-> cmd_start_out ##[0:1] cmd_block_out) else $error("ready without block");
  a_ready_pulse: assert property (
    cmd_ready_out |=> !cmd_ready_out) else $error("ready too long");
  a_drives_follow: assert property (
    reset_n_in && $past(reset_n_in) |=> {chain_switch_drive_out, response_current_level_out,
    response_current_double_out} == $past({chain_switch_close_in, resp_single_req_in,
    resp_double_req_in})) else $error("drive output not following request");
endmodule
bind sbcr_top sbcr_properties chk (.*);
`default_nettype wire

// ---- test/sbcr_master.sv ----
// Purpose: Bus master model sending supply-modulated commands
// Assumes: Driven 2 ns after the clock edge
// Notes: Bit line shows the inverse value between strobes
`timescale 1ns/10ps
`default_nettype none
module sbcr_master (
  input wire logic ref_clk_in,
  output var logic cmd_level_out,
  output var logic bit_value_out,
  output var logic bit_strobe_out
);
  initial begin
    cmd_level_out = 1'b1;
    bit_value_out = 1'b0;
    bit_strobe_out = 1'b0;
  end
  // Low level for low cycles, then n bits MSB first
  task automatic send(input logic [31:0] v, input int n, input int low);
    @(posedge ref_clk_in) #2 cmd_level_out = 1'b0;
    repeat (low) @(posedge ref_clk_in);
    #2 cmd_level_out = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (3) @(posedge ref_clk_in);
      #2 bit_value_out = v[i];
      bit_strobe_out = 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #2 bit_strobe_out = 1'b0;
      bit_value_out = ~v[i];
    end
  endtask
endmodule
`default_nettype wire

// ---- test/test_sensor_bus_command_receiver.sv ----
// Purpose: Self-checking bench of the command receiver
// Assumes: 20 MHz clock, inputs driven 2 ns after the edge
// Notes: One command per op_mode_in value, 3 decoded as PDCM, results checked on ready
`timescale 1ns/10ps
`default_nettype none
`include "sbcr_map.vh"
module test_sensor_bus_command_receiver;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] op_mode_in = 2'h0;
  logic [3:0] rnd = 4'h0;
  wire det, bitv, strb, start, valid, block, samp, ready;
  wire lvl, dbl, dsl, chn;
  logic [3:0] r1 = 4'h0;
  logic [3:0] r2 = 4'h0;
  logic ds_exp = 1'b0;
  wire [31:0] data;
  wire [5:0] len;
  int failures = 0;
  int samples_checked = 0;
  int seed = 29777;
  int lens[4] = '{`SBCR_BITS_DISC, `SBCR_BITS_CRM, `SBCR_BITS_PDCM, `SBCR_BITS_PDCM};
  logic [37:0] exp_q[$];
  logic [37:0] note;
  logic [31:0] v;
  always #25 ref_clk_in = ~ref_clk_in;
  sbcr_master far (.ref_clk_in(ref_clk_in), .cmd_level_out(det), .bit_value_out(bitv),
    .bit_strobe_out(strb));
  sbcr_top uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_detect_in(det),
    .cmd_bit_in(bitv), .cmd_bit_strobe_in(strb), .op_mode_in(op_mode_in),
    .chain_switch_close_in(rnd[0]), .resp_single_req_in(rnd[1]), .resp_double_req_in(rnd[2]),
    .downstream_sense_in(rnd[3]), .cmd_start_out(start), .cmd_valid_out(valid),
    .cmd_block_out(block), .high_ref_sampling_enable_out(samp), .cmd_data_out(data),
    .cmd_len_out(len), .cmd_ready_out(ready), .response_current_level_out(lvl),
    .response_current_double_out(dbl), .downstream_slave_out(dsl),
    .chain_switch_drive_out(chn));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait for the end of the current command
  task automatic wait_idle;
    for (int k = 0; k < 6000 && start !== 1'b0; k++) @(posedge ref_clk_in) #1;
    if (start !== 1'b0) begin
      failures++;
      report_and_stop;
    end
  endtask
  // Random switch, current and sense requests
  always @(posedge ref_clk_in) #2 rnd = 4'($random(seed));
  // Hand-over monitor against the oldest note
  always @(posedge ref_clk_in) begin
    #1;
    // Level outputs: requests one clock late, sense two flops plus one
    if (reset_n_in !== 1'b1) begin
      r1 = 4'h0;
      r2 = 4'h0;
      ds_exp = 1'b0;
      check({31'h0, chn}, 32'h0);
    end else begin
      check({29'h0, chn, dbl, lvl}, {29'h0, rnd[0], rnd[2], rnd[1]});
      if (op_mode_in == 2'h0) ds_exp = r2[3];
      check({31'h0, dsl}, {31'h0, ds_exp});
      r2 = r1;
      r1 = rnd;
    end
    if (ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else begin
        note = exp_q.pop_front();
        check({26'h0, len}, {26'h0, note[37:32]});
        check(data & ~(32'hFFFFFFFF << note[37:32]), note[31:0]);
      end
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_in);
    #2 reset_n_in = 1'b1;
    repeat (1990) @(posedge ref_clk_in);
    #1 check({31'h0, samp}, 32'h0);
    repeat (15) @(posedge ref_clk_in);
    #1 check({31'h0, samp}, 32'h1);
    // Microcut: short low, start rises, no valid, start drops at window end
    far.send(32'h0, 0, 5);
    repeat (100) @(posedge ref_clk_in);
    #1 check({28'h0, start, samp, valid, block}, 32'h8);
    repeat (70) @(posedge ref_clk_in);
    #1 check({28'h0, start, samp, valid, block}, 32'h4);
    for (int mi = 0; mi < 4; mi++) begin
      #1 op_mode_in = 2'(mi);
      v = $random(seed) & ~(32'hFFFFFFFF << lens[mi]);
      exp_q.push_back({6'(lens[mi]), v});
      far.send(v, lens[mi], 30 + 40 * mi);
      wait_idle;
      check({29'h0, samp, valid, block}, 32'h4);
      check(32'(exp_q.size()), 32'h0);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
